// ---- hw/dscu_consts.svh ----
/*
 * Named constants for the debug serial command unit: response codes,
 * command fields, operand counts and register offsets.
 * Assumes it is included by bare name from the files that need it.
 */
`ifndef DSCU_CONSTS_SVH
`define DSCU_CONSTS_SVH

// ==========================================================
// Serial responses
`define DSCU_RESP_OK 17'h0FFFF
`define DSCU_RESP_NOT_READY 17'h10000
`define DSCU_RESP_BUS_ERR 17'h10001
`define DSCU_RESP_ILLEGAL 17'h1FFFF

// ==========================================================
// Command word fields
`define DSCU_OP_REG 6'h08
`define DSCU_OP_MEM 6'h06
`define DSCU_OP_BLOCK 6'h07
`define DSCU_SZ_BYTE 2'h0
`define DSCU_SZ_WORD 2'h1
`define DSCU_SZ_LONG 2'h2
`define DSCU_SZ_RSVD 2'h3
`define DSCU_NOP_WORD 16'h0000

// ==========================================================
// Frame and operand counts
`define DSCU_LAST_BIT 5'h10
`define DSCU_OPS_ADDR 3'h2
`define DSCU_OPS_LONG 3'h2
`define DSCU_OPS_SHORT 3'h1

// ==========================================================
// Bus register map and reset values
`define DSCU_OFF_ATTR 8'h00
`define DSCU_OFF_BKPT 8'h04
`define DSCU_OFF_STAT 8'h08
`define DSCU_ATTR_RST 5'h05
`define DSCU_AXI_OKAY 2'h0
`define DSCU_AXI_SLVERR 2'h2

`endif

// ---- hw/dscu_pkg.sv ----
/*
 * Types of the debug serial command unit: state codes and the packed
 * state record. Assumes dscu_consts.svh is not needed here.
 */
package dscu_pkg;

    // ==========================================================
    // Enumerations
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_OPER = 3'b010,
        ST_BUSY = 3'b100
    } dscu_state_type;

    typedef enum logic [4:0] {
        K_OTHER = 5'b00001,
        K_READ = 5'b00010,
        K_WRITE = 5'b00100,
        K_DUMP = 5'b01000,
        K_FILL = 5'b10000
    } dscu_kind_type;

    // ==========================================================
    // Whole state of the unit
    typedef struct packed {
        logic sclkS1, sclkS2, sclkS3, dsiS1, dsiS2;
        logic [4:0] bitCnt;
        logic [16:0] shIn, shOut;
        dscu_state_type st;
        dscu_kind_type lastKind;
        logic [15:0] cmd;
        logic [2:0] opLeft;
        logic [63:0] opnd;
        logic [16:0] q0, q1;
        logic [1:0] resCnt;
        logic [4:0] attr;
        logic [31:0] bkpt;
        logic [15:0][31:0] regs;
        logic memReq, memWrite;
        logic [1:0] memSize;
        logic [4:0] memSpace;
        logic [31:0] memAddr, memWdata;
        logic awHave, wHave, bvalid, rvalid;
        logic [7:0] awAddr;
        logic [31:0] wData, rdata;
        logic [3:0] wStrb;
        logic [1:0] bresp, rresp;
    } dscu_state_rec_type;

endpackage : dscu_pkg

// ---- hw/dscu_core.sv ----
/*
 * Debug serial command unit: takes 17-bit frames on the serial debug
 * link, runs register and memory commands, returns 17-bit responses.
 * Assumes the core's halted flag and the memory port share ref_clk, and
 * that the link clock is far slower than ref_clk (a few cycles per level).
 */
// Our own choices: the address map and the AXI4-Lite interface to the registers.
// How it works
// - Good results leave bit 16 of every response word at zero.
// - Not-ready, bus error and illegal responses set bit 16.
// - Register read returns 32 bits as two words, upper first.
// - Register commands are refused with bus error while the core runs.
// - Register write takes a longword, replaces all bits, answers 0FFFF.
// - Memory commands take their space from the low five attribute bits.
// - Word and longword addresses are forced to natural alignment.
// - Byte result sits in low byte; word gives 16, long 32 bits.
// - Read success clears bit 16; read bus error returns 10001.
// - Write success answers 0FFFF; write bus error answers 10001.
// - Reads and dumps leave address plus size in the breakpoint register.
// - Dump is legal only after dump, no-op or memory read.
// - No-op leaves the saved block address untouched.
// - Each dump decodes its own operand size.
// - Dump results look like read results and need no operands.
// - Writes and fills leave address plus size in the breakpoint register.
// - Fill is legal only after fill, no-op or memory write.
// - Each fill decodes its own operand size.
// - Frames arriving during a memory access answer 10000.
// - Unimplemented commands answer 1FFFF; host then retransmits.
// - Direction bit set reads toward host, clear writes from host.
`timescale 1ns/1ps
`default_nettype none
`include "dscu_consts.svh"

module dscu_core
    import dscu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic dsclk,
    input wire logic dsi,
    output logic dso,
    input wire logic halted,
    output logic memReq,
    output logic memWrite,
    output logic [1:0] memSize,
    output logic [4:0] memSpace,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    input wire logic [31:0] memRdata,
    input wire logic memAck,
    input wire logic memErr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);

    dscu_state_rec_type q;
    dscu_state_rec_type d;

    // ==========================================================
    // Helpers
    // Byte-lane merge for bus writes.
    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return v;
    endfunction : laneMerge

    // Operand size in bytes: 1, 2 or 4.
    function automatic logic [31:0] sizeInc(input logic [1:0] sz);
        case (sz)
            `DSCU_SZ_WORD: sizeInc = 32'h00000002;
            `DSCU_SZ_LONG: sizeInc = 32'h00000004;
            default: sizeInc = 32'h00000001;
        endcase
    endfunction : sizeInc

    // Natural alignment by clearing low address bits.
    function automatic logic [31:0] alignAddr(input logic [31:0] a, input logic [1:0] sz);
        case (sz)
            `DSCU_SZ_WORD: alignAddr = {a[31:1], 1'b0};
            `DSCU_SZ_LONG: alignAddr = {a[31:2], 2'h0};
            default: alignAddr = a;
        endcase
    endfunction : alignAddr

    // ==========================================================
    // Link edge and command decode
    // The edge detector reads stage two and three; stage one feeds only stage two.
    logic sclkRise, frameDone, idleCmd, memDone, basicOk;
    logic [15:0] wordIn;
    logic [5:0] opField;
    logic [1:0] szField;
    logic rwBit;
    logic isNop, isRegRd, isRegWr, isRead, isWrite, isDump, isFill;
    assign sclkRise = q.sclkS2 & ~q.sclkS3;
    assign frameDone = sclkRise && (q.bitCnt == `DSCU_LAST_BIT);
    assign wordIn = {q.shIn[14:0], q.dsiS2};
    assign idleCmd = frameDone && (q.st == ST_IDLE) && (q.resCnt == 2'h0);
    assign memDone = (q.st == ST_BUSY) && (memAck || memErr);
    assign opField = wordIn[15:10];
    assign szField = wordIn[7:6];
    assign rwBit = wordIn[8];
    assign basicOk = (wordIn[9] == 1'b0) && (wordIn[5:4] == 2'h0);
    assign isNop = (wordIn == `DSCU_NOP_WORD);
    assign isRegRd = basicOk && opField == `DSCU_OP_REG && rwBit && szField == `DSCU_SZ_LONG;
    assign isRegWr = basicOk && opField == `DSCU_OP_REG && !rwBit && szField == `DSCU_SZ_LONG;
    assign isRead = basicOk && opField == `DSCU_OP_MEM && rwBit && szField != `DSCU_SZ_RSVD;
    assign isWrite = basicOk && opField == `DSCU_OP_MEM && !rwBit && szField != `DSCU_SZ_RSVD;
    assign isDump = basicOk && opField == `DSCU_OP_BLOCK && rwBit && szField != `DSCU_SZ_RSVD
                    && (q.lastKind == K_READ || q.lastKind == K_DUMP);
    assign isFill = basicOk && opField == `DSCU_OP_BLOCK && !rwBit && szField != `DSCU_SZ_RSVD
                    && (q.lastKind == K_WRITE || q.lastKind == K_FILL);

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic [63:0] newOp;
        logic [31:0] wAddr, wData;
        logic isLong;
        d = q;
        newOp = {q.opnd[47:0], wordIn};
        isLong = (q.cmd[7:6] == `DSCU_SZ_LONG);
        wAddr = isLong ? newOp[63:32] : newOp[47:16];
        wData = isLong ? newOp[31:0] : {16'h0000, newOp[15:0]};
        d.sclkS1 = dsclk;
        d.sclkS2 = q.sclkS1;
        d.sclkS3 = q.sclkS2;
        d.dsiS1 = dsi;
        d.dsiS2 = q.dsiS1;

        // Register bus: address and data may arrive in either order.
        if (awvalid && awready) begin
            d.awHave = 1'b1;
            d.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            d.wHave = 1'b1;
            d.wData = wdata;
            d.wStrb = wstrb;
        end
        if (q.awHave && q.wHave && !q.bvalid) begin
            d.awHave = 1'b0;
            d.wHave = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `DSCU_AXI_OKAY;
            if (q.awAddr == `DSCU_OFF_ATTR) begin
                d.attr = 5'(laneMerge({27'h0, q.attr}, q.wData, q.wStrb));
            end else if (q.awAddr == `DSCU_OFF_BKPT) begin
                d.bkpt = laneMerge(q.bkpt, q.wData, q.wStrb);
            end else if (q.awAddr == `DSCU_OFF_STAT) begin
                d.bresp = `DSCU_AXI_OKAY;
            end else begin
                d.bresp = `DSCU_AXI_SLVERR;
            end
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            d.rvalid = 1'b1;
            d.rresp = `DSCU_AXI_OKAY;
            if (araddr == `DSCU_OFF_ATTR) begin
                d.rdata = {27'h0, q.attr};
            end else if (araddr == `DSCU_OFF_BKPT) begin
                d.rdata = q.bkpt;
            end else if (araddr == `DSCU_OFF_STAT) begin
                d.rdata = {23'h0, q.lastKind, q.st, halted};
            end else begin
                d.rdata = 32'h00000000;
                d.rresp = `DSCU_AXI_SLVERR;
            end
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end

        // Link shifter: sample on the rising link edge, present the next bit after it.
        if (sclkRise) begin
            d.shIn = {q.shIn[15:0], q.dsiS2};
            d.shOut = {q.shOut[15:0], 1'b0};
            d.bitCnt = q.bitCnt + 5'h01;
        end

        // Frame end: choose the response of the next frame.
        if (frameDone) begin
            d.bitCnt = 5'h00;
            if (q.st == ST_BUSY) begin
                d.shOut = `DSCU_RESP_NOT_READY;
            end else if (q.resCnt != 2'h0) begin
                // Word received alongside a non-final result is filler.
                d.shOut = q.q0;
                d.q0 = q.q1;
                d.resCnt = q.resCnt - 2'h1;
            end else if (q.st == ST_OPER) begin
                d.opnd = newOp;
                d.shOut = `DSCU_RESP_NOT_READY;
                d.opLeft = q.opLeft - 3'h1;
                if (q.opLeft == 3'h1) begin
                    d.st = ST_BUSY;
                    d.memReq = 1'b1;
                    d.memSize = q.cmd[7:6];
                    d.memSpace = q.attr;
                    d.memWrite = !q.cmd[8];
                    if (q.cmd[15:10] == `DSCU_OP_REG) begin
                        d.st = ST_IDLE;
                        d.memReq = 1'b0;
                        if (halted) begin
                            d.regs[q.cmd[3:0]] = newOp[31:0];
                            d.shOut = `DSCU_RESP_OK;
                        end else begin
                            d.shOut = `DSCU_RESP_BUS_ERR;
                        end
                    end else if (q.cmd[15:10] == `DSCU_OP_BLOCK) begin
                        d.memAddr = alignAddr(q.bkpt, q.cmd[7:6]);
                        d.memWdata = wData;
                    end else if (q.cmd[8]) begin
                        d.memAddr = alignAddr(newOp[31:0], q.cmd[7:6]);
                    end else begin
                        d.memAddr = alignAddr(wAddr, q.cmd[7:6]);
                        d.memWdata = wData;
                    end
                end
            end else begin
                d.cmd = wordIn;
                d.lastKind = K_OTHER;
                if (isNop) begin
                    d.lastKind = q.lastKind;
                    d.shOut = `DSCU_RESP_OK;
                end else if (isRegRd) begin
                    if (halted) begin
                        d.shOut = {1'b0, q.regs[wordIn[3:0]][31:16]};
                        d.q0 = {1'b0, q.regs[wordIn[3:0]][15:0]};
                        d.resCnt = 2'h1;
                    end else begin
                        d.shOut = `DSCU_RESP_BUS_ERR;
                    end
                end else if (isRegWr) begin
                    d.st = ST_OPER;
                    d.opLeft = `DSCU_OPS_LONG;
                    d.shOut = `DSCU_RESP_NOT_READY;
                end else if (isRead || isWrite) begin
                    d.st = ST_OPER;
                    d.lastKind = isRead ? K_READ : K_WRITE;
                    if (isRead) begin
                        d.opLeft = `DSCU_OPS_ADDR;
                    end else if (szField == `DSCU_SZ_LONG) begin
                        d.opLeft = `DSCU_OPS_ADDR + `DSCU_OPS_LONG;
                    end else begin
                        d.opLeft = `DSCU_OPS_ADDR + `DSCU_OPS_SHORT;
                    end
                    d.shOut = `DSCU_RESP_NOT_READY;
                end else if (isDump) begin
                    // Dump carries no operands and starts its read at once.
                    d.lastKind = K_DUMP;
                    d.st = ST_BUSY;
                    d.memReq = 1'b1;
                    d.memWrite = 1'b0;
                    d.memSize = szField;
                    d.memSpace = q.attr;
                    d.memAddr = alignAddr(q.bkpt, szField);
                    d.shOut = `DSCU_RESP_NOT_READY;
                end else if (isFill) begin
                    d.lastKind = K_FILL;
                    d.st = ST_OPER;
                    d.opLeft = (szField == `DSCU_SZ_LONG) ? `DSCU_OPS_LONG : `DSCU_OPS_SHORT;
                    d.shOut = `DSCU_RESP_NOT_READY;
                end else begin
                    d.shOut = `DSCU_RESP_ILLEGAL;
                end
            end
        end

        // Memory completion queues the results for the following frames.
        if (memDone) begin
            d.memReq = 1'b0;
            d.st = ST_IDLE;
            d.bkpt = q.memAddr + sizeInc(q.memSize);
            d.resCnt = 2'h1;
            if (q.memWrite) begin
                d.q0 = memErr ? `DSCU_RESP_BUS_ERR : `DSCU_RESP_OK;
            end else if (memErr) begin
                d.q0 = `DSCU_RESP_BUS_ERR;
            end else if (q.memSize == `DSCU_SZ_LONG) begin
                d.q0 = {1'b0, memRdata[31:16]};
                d.q1 = {1'b0, memRdata[15:0]};
                d.resCnt = 2'h2;
            end else if (q.memSize == `DSCU_SZ_WORD) begin
                d.q0 = {1'b0, memRdata[15:0]};
            end else begin
                d.q0 = {9'h000, memRdata[7:0]};
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.lastKind <= K_OTHER;
            q.attr <= `DSCU_ATTR_RST;
            q.shOut <= `DSCU_RESP_OK;
        end else begin
            q <= d;
        end
    end

    // Outputs; bus readies are combinational, everything else is a flop.
    assign dso = q.shOut[16];
    assign memReq = q.memReq;
    assign memWrite = q.memWrite;
    assign memSize = q.memSize;
    assign memSpace = q.memSpace;
    assign memAddr = q.memAddr;
    assign memWdata = q.memWdata;
    assign awready = !q.awHave && !q.bvalid;
    assign wready = !q.wHave && !q.bvalid;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = !q.rvalid;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence seqRegWrLast;
        frameDone && q.st == ST_OPER && q.resCnt == 2'h0 && q.opLeft == 3'h1
            && q.cmd[15:10] == `DSCU_OP_REG;
    endsequence
    sequence seqMemFinish;
        memDone && !memErr;
    endsequence

    chk_busy_not_ready: assert property (frameDone && q.st == ST_BUSY
        |=> q.shOut == `DSCU_RESP_NOT_READY) else $error("busy frame not answered 10000");
    chk_illegal_answer: assert property (idleCmd && !(isNop || isRegRd || isRegWr || isRead
        || isWrite || isDump || isFill) |=> q.shOut == `DSCU_RESP_ILLEGAL)
        else $error("illegal command not answered 1FFFF");
    chk_reg_refused: assert property ((idleCmd && isRegRd || frameDone && q.st == ST_OPER
        && q.resCnt == 2'h0 && q.opLeft == 3'h1 && q.cmd[15:10] == `DSCU_OP_REG) && !halted
        |=> q.shOut == `DSCU_RESP_BUS_ERR && q.st == ST_IDLE)
        else $error("running core not refused");
    chk_reg_write_done: assert property (seqRegWrLast ##0 halted
        |=> q.shOut == `DSCU_RESP_OK && q.regs[q.cmd[3:0]] == $past(q.opnd[47:16] & 32'h0) +
        {$past(q.opnd[15:0]), $past(wordIn)}) else $error("register write wrong");
    chk_mem_space: assert property ($rose(q.memReq) |-> q.memSpace == $past(q.attr))
        else $error("memory space not from attribute bits");
    chk_long_align: assert property (q.memReq && q.memSize == `DSCU_SZ_LONG
        |-> q.memAddr[1:0] == 2'h0) else $error("long access misaligned");
    chk_req_hold: assert property (q.memReq && !memAck && !memErr
        |=> q.memReq && $stable(q.memAddr) && q.st == ST_BUSY) else $error("request dropped");
    chk_bkpt_incr: assert property (seqMemFinish
        |=> q.bkpt == $past(q.memAddr) + sizeInc($past(q.memSize))) else $error("pointer not advanced");
    chk_read_error: assert property (memDone && memErr && !q.memWrite
        |=> q.q0 == `DSCU_RESP_BUS_ERR && q.resCnt == 2'h1) else $error("read error not 10001");
    chk_nop_keeps: assert property (idleCmd && isNop && !(q.awHave && q.wHave && !q.bvalid)
        |=> $stable(q.bkpt) && $stable(q.lastKind)) else $error("no-op changed pointer");
    chk_dump_order: assert property (idleCmd && opField == `DSCU_OP_BLOCK && rwBit
        && q.lastKind != K_READ && q.lastKind != K_DUMP |=> q.shOut == `DSCU_RESP_ILLEGAL)
        else $error("dump accepted out of order");
    chk_fill_order: assert property (idleCmd && opField == `DSCU_OP_BLOCK && !rwBit
        && q.lastKind != K_WRITE && q.lastKind != K_FILL |=> q.shOut == `DSCU_RESP_ILLEGAL)
        else $error("fill accepted out of order");

endmodule : dscu_core
`default_nettype wire

// ---- verif/dscu_host.sv ----
/*
 * Host side of the serial debug link: sends one 17-bit frame per call and
 * returns the 17-bit response shifted out at the same time.
 * Assumes the caller spaces frames by calling xfer in sequence only.
 */
`timescale 1ns/1ps
`default_nettype none
module dscu_host (
    output logic dsclk,
    output logic dsi,
    input wire logic dso
);
    // ==========================================================
    // Frame shifter
    // The link clock idles low between frames, so the unit sees no stray edges.
    task automatic xfer(input logic [15:0] w, output logic [16:0] r);
        logic [16:0] f;
        f = {1'b0, w};
        for (int i = 16; i >= 0; i--) begin
            dsi <= f[i];
            #100;
            r[i] = dso;
            dsclk <= 1'b1;
            #100;
            dsclk <= 1'b0;
        end
        // A released data line must not keep showing the last bit.
        dsi <= ~dsi;
        #300;
    endtask : xfer

    // Idle levels before the first frame.
    initial begin
        dsclk = 1'b0;
        dsi = 1'b1;
    end
endmodule : dscu_host
`default_nettype wire

// ---- verif/debug_serial_command_unit_tb.sv ----
/*
 * Bench of the debug serial command unit: link host, memory port model and
 * register bus master, with expectations kept in integers and flags here.
 * Assumes dscu_pkg, dscu_core and dscu_host are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module debug_serial_command_unit_tb;
    // ==========================================================
    // Signals and model state
    logic ref_clk, dso, memReq, memWrite, awready, wready, bvalid, arready, rvalid, dsclk, dsi;
    logic rst = 1'b1, halted = 1'b1, memAck = 1'b0, memErr = 1'b0, eWr = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic errMode = 1'b0, slow = 1'b0;
    logic [1:0] memSize, bresp, rresp, rs, eSz = 2'h0;
    logic [3:0] wstrb = 4'hF;
    logic [4:0] memSpace, attr;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [15:0] c;
    logic [31:0] memAddr, memWdata, rdata, d, ptr, eAd = '0, eWd = '0, rdv = '0;
    logic [31:0] memRdata = '0, wdata = '0, st = 32'h110C8;
    logic [33:0] pExp, pMask;
    int n_fail = 0, checks = 0, pN = 0, nWait = 0, cnt = 0, dly = 3;

    dscu_core u_dut (.*);
    dscu_host u_host (.*);

    // ==========================================================
    // Clock, and a watchdog of some 400 frames, about four times the hundred or so expected.
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        #1500000;
        n_fail++;
        report_and_stop();
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction : rnd

    task automatic chk(input logic [39:0] s, input logic [39:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= v;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge ref_clk); while (!bvalid);
        chk(bresp, a > 8'h08 ? 2'h2 : 2'h0);
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        @(posedge ref_clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge ref_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (!rvalid);
        v = rdata;
        s = rresp;
        rready <= 1'b0;
    endtask : axr

    // Collects the previous command's results (its last frame carries cm), then operands.
    task automatic go(input logic [15:0] cm, input logic [63:0] o, input int no, input int nr,
                      input logic [33:0] e, input logic [33:0] m);
        logic [16:0] r;
        logic [33:0] got;
        int i;
        got = '0;
        i = 0;
        while (i < pN) begin
            u_host.xfer(cm, r);
            if (r === 17'h10000 && i == 0) begin
                nWait++;
            end else begin
                got = {got[16:0], r};
                i = r[16] ? pN : i + 1;
            end
        end
        if (pN == 0) u_host.xfer(cm, r);
        else chk(got & pMask, pExp & pMask);
        for (int k = 0; k < no; k++) u_host.xfer(o[63 - 16 * k -: 16], r);
        pN = nr;
        pExp = e;
        pMask = m;
    endtask : go

    // One memory command; a plain read or write when ad is set, else a block step.
    task automatic acc(input logic [7:0] op, input int s, input logic [31:0] a, input logic ad);
        int sz;
        int nr;
        logic [31:0] w;
        logic [33:0] e;
        sz = 1 << s;
        eSz = 2'(s);
        eWr = !op[0];
        eAd = a & ~(sz - 1);
        ptr = eAd + 32'(sz);
        eWd = rnd() & (s == 2 ? 32'hFFFFFFFF : s == 1 ? 32'h0000FFFF : 32'h000000FF);
        rdv = rnd();
        w = s == 2 ? eWd : {eWd[15:0], 16'h0000};
        nr = (!errMode && !eWr && s == 2) ? 2 : 1;
        e = errMode ? 34'h10001 : eWr ? 34'h0FFFF : {1'b0, rdv[31:16] & {16{nr[1]}}, 1'b0, rdv[15:0]};
        go({op, 2'(s), 6'h00}, ad ? {a, w} : {w, 32'h0}, (ad ? 2 : 0) + (eWr ? 1 + s / 2 : 0), nr,
           e, (s == 0 && !eWr && !errMode) ? 34'h100FF : 34'h3FFFFFFFF);
    endtask : acc

    // ==========================================================
    // Memory port: answers after a short random or a long delay, checks each request once.
    always @(posedge ref_clk) begin
        if (memAck || memErr) begin
            memAck <= 1'b0;
            memErr <= 1'b0;
            memRdata <= ~memRdata;
            cnt <= 0;
        end else if (memReq) begin
            if (cnt == 0) chk({memSize, memWrite, memSpace, memAddr}, {eSz, eWr, attr, eAd});
            if (cnt == 0 && eWr) chk(memWdata, eWd);
            cnt <= cnt + 1;
            if (cnt == (slow ? 400 : dly)) begin
                memAck <= !errMode;
                memErr <= errMode;
                memRdata <= rdv;
                dly <= rnd() % 8;
            end
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        attr = 5'(rnd());
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (8) @(posedge ref_clk);
        axr(8'h00, d, rs);
        chk({rs, d}, {2'h0, 32'h5});
        axw(8'h00, {27'h0, attr});
        axw(8'h0C, rnd());
        axr(8'h0C, d, rs);
        chk({rs, d}, {2'h2, 32'h0});
        for (int k = 0; k < 4; k++) begin
            d = rnd();
            c = {12'h208, k[0], 3'(rnd())};
            go(c, {d, 32'h0}, 2, 1, 34'h0FFFF, 34'h1FFFF);
            go(c | 16'h0100, '0, 0, 2, {1'b0, d[31:16], 1'b0, d[15:0]}, 34'h3FFFFFFFF);
        end
        for (int s = 0; s < 3; s++) begin
            acc(8'h18, s, rnd(), 1'b1);
            go(16'h0000, '0, 0, 1, 34'h0FFFF, 34'h3FFFFFFFF);
            acc(8'h1C, s, ptr, 1'b0);
            acc(8'h1C, 0, ptr, 1'b0);
            acc(8'h19, s, rnd(), 1'b1);
            acc(8'h1D, s, ptr, 1'b0);
            acc(8'h1D, 0, ptr, 1'b0);
        end
        // Slow memory with transfer errors: frames meanwhile must report not ready.
        nWait = 0;
        slow = 1'b1;
        errMode = 1'b1;
        acc(8'h19, 2, rnd(), 1'b1);
        acc(8'h18, 1, rnd(), 1'b1);
        chk(nWait > 1, 1'b1);
        // Let the slow failing write finish before the model's mode changes under it.
        wait (memReq);
        wait (!memReq);
        errMode = 1'b0;
        slow = 1'b0;
        go(16'h1D80, '0, 0, 1, 34'h1FFFF, 34'h3FFFFFFFF);
        acc(8'h19, 0, rnd(), 1'b1);
        go(16'h1C40, '0, 0, 1, 34'h1FFFF, 34'h3FFFFFFFF);
        go(16'h19C0, '0, 0, 1, 34'h1FFFF, 34'h3FFFFFFFF);
        @(posedge ref_clk);
        halted <= 1'b0;
        go(16'h2188, '0, 0, 1, 34'h10001, 34'h3FFFFFFFF);
        go(16'h2083, 64'h0, 2, 1, 34'h10001, 34'h3FFFFFFFF);
        go(16'h0000, '0, 0, 0, '0, '0);
        axr(8'h04, d, rs);
        chk({rs, d}, {2'h0, ptr});
        axr(8'h08, d, rs);
        chk({rs, d}, {2'h0, 32'h00000012});
        report_and_stop();
    end
endmodule : debug_serial_command_unit_tb
`default_nettype wire
